//--- ee_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Same clock on both sides; no crossing inside.
`timescale 1ns/100ps
module ee_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : ee_fifo

//--- ee_link_assertions.sv
// Concurrent checks on the two-wire link between the EEPROM slave and master.
// Assumes one clock, clk_sys, and a synchronous active-high rst.
`timescale 1ns/100ps
module ee_link_assertions #(
	parameter int WRITE_CYC = 200
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl_m_oe,
	input wire logic sda_m_oe,
	input wire logic sda_s_oe,
	input wire logic scl,
	input wire logic sda,
	input wire logic busy
);
	import ee_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// ****
	// Helpers
	// ****
	int busy_len;
	always_ff @(posedge clk_sys) begin
		if (rst || !busy) begin
			busy_len <= 0;
		end else begin
			busy_len <= busy_len + 1;
		end
	end
	sequence start_cond;
		scl && $fell(sda);
	endsequence
	sequence stop_cond;
		scl && $rose(sda);
	endsequence

	// ****
	// Checks
	// ****
	a_reset_idle: assert property ($fell(rst) |-> !scl_m_oe && !sda_m_oe && !sda_s_oe)
		else $error("link drivers active after reset");
	a_slave_edge: assert property ($changed(sda_s_oe) |-> !scl)
		else $error("slave changed data while clock high");
	a_busy_no_ack: assert property (busy |-> !sda_s_oe)
		else $error("slave drove data during write cycle");
	a_busy_at_stop: assert property ($rose(busy) |-> scl && sda)
		else $error("write cycle began outside a stop");
	a_busy_len: assert property ($fell(busy) |-> busy_len >= WRITE_CYC - 2
		&& busy_len <= WRITE_CYC + 2)
		else $error("write cycle length wrong");
	a_stop_release: assert property (stop_cond |=> !sda_s_oe [*8])
		else $error("slave drove data after stop");
	a_start_release: assert property (start_cond |=> !sda_s_oe [*8])
		else $error("slave drove data during control byte");
	a_poll_ack: assert property ($fell(busy) |-> ##[1:1000] sda_s_oe)
		else $error("no acknowledge after write cycle ended");
endmodule : ee_link_assertions

//--- ee_link_if.sv
// Two-wire link between the EEPROM slave and its master.
// Open drain lines: a wire reads low when either end enables its driver.
`timescale 1ns/100ps
interface ee_link_if;
	logic scl_m_oe;
	logic sda_m_oe;
	logic sda_s_oe;
	logic scl;
	logic sda;

	assign scl = ~scl_m_oe;
	assign sda = ~(sda_m_oe | sda_s_oe);

	modport slave (input scl, input sda, output sda_s_oe);
	modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface : ee_link_if

//--- ee_master.sv
// Bus master end: takes commands from a user port, drives clock and data
// lines, polls for acknowledge, and queues read bytes in a FIFO.
// Assumes the slave acknowledges within the same bit time.
`timescale 1ns/100ps
module ee_master (
	input wire logic clk_sys,
	input wire logic rst,
	ee_link_if.master link,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire ee_pkg::ee_cmd_t cmd,
	input wire logic [2:0] cmd_cs,
	input wire logic [14:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	input wire logic [7:0] cmd_len,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic nack
);
	import ee_pkg::*;

	// ****************************************************
	// Bit clock divider and pin sampling
	// ****************************************************
	logic [7:0] div;
	logic tick;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div <= EE_DIV_RST;
		end else begin
			div <= (div == 8'(EE_SCL_HALF - 1)) ? EE_DIV_RST : div + 8'h1;
		end
	end
	assign tick = (div == 8'(EE_SCL_HALF - 1));
	logic [1:0] sda_sync;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sda_sync <= 2'h3;
		end else begin
			sda_sync <= {sda_sync[0], link.sda};
		end
	end

	// ****************************************************
	// Sequencer: a flat list of bytes with start, restart and stop
	// ****************************************************
	logic busy_m;
	logic [2:0] phase;
	logic [3:0] bitn;
	logic [2:0] step;
	logic [7:0] txb;
	logic [7:0] rxb;
	logic [7:0] left;
	logic [14:0] a;
	logic [7:0] d;
	logic [2:0] cs;
	ee_cmd_t kind;
	logic scl_oe;
	logic sda_oe;
	logic fifo_ready;
	logic push;
	logic [7:0] push_data;

	assign cmd_ready = !busy_m;
	function automatic logic [7:0] ctrl(input logic [2:0] c, input logic r);
		ctrl = {EE_DEV_CODE, c, r};
	endfunction : ctrl

	// Phases: 0 start, 1 first clock low, 2..4 one bit over three ticks, 5 stop, 6 restart, 7 stop finish
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			busy_m <= 1'b0;
			phase <= 3'h0;
			bitn <= EE_BIT_RST;
			step <= 3'h0;
			txb <= EE_DATA_RST;
			rxb <= EE_DATA_RST;
			left <= EE_DATA_RST;
			a <= EE_ADDR_RST;
			d <= EE_DATA_RST;
			cs <= 3'h0;
			kind <= EE_CMD_WRITE;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
			nack <= 1'b0;
			push <= 1'b0;
			push_data <= EE_DATA_RST;
		end else begin
			push <= 1'b0;
			if (cmd_valid && !busy_m) begin
				busy_m <= 1'b1;
				kind <= cmd;
				a <= cmd_addr;
				d <= cmd_data;
				cs <= cmd_cs;
				left <= cmd_len;
				step <= 3'h0;
				phase <= 3'h0;
				nack <= 1'b0;
				// Random read opens as a write of the address
				// A current address read opens directly with the read bit
				txb <= ctrl(cmd_cs, cmd == EE_CMD_CUR);
			end else if (busy_m && tick && fifo_ready) begin
				case (phase)
					3'h0: begin
						sda_oe <= 1'b1; // Start: data falls while clock high
						phase <= 3'h1;
						bitn <= EE_BIT_RST;
					end
					3'h1: begin
						scl_oe <= 1'b1;
						phase <= 3'h2;
					end
					3'h2: begin
						// Drive bit; release for slave ack or read bits; ack each read byte except the last
						if (bitn == EE_BIT_ACK) begin
							sda_oe <= (step == 3'h5) && (left != 8'h1);
						end else begin
							sda_oe <= (step == 3'h5) ? 1'b0 : !txb[3'(4'h7 - bitn)];
						end
						phase <= 3'h3;
					end
					3'h3: begin
						scl_oe <= 1'b0;
						if (bitn < EE_BIT_ACK) begin
							rxb <= {rxb[6:0], sda_sync[1]};
						end
						phase <= 3'h4;
					end
					3'h4: begin
						scl_oe <= 1'b1;
						if (bitn != EE_BIT_ACK) begin
							bitn <= bitn + 4'h1;
							phase <= 3'h2;
						end else if (step != 3'h5 && sda_sync[1]) begin
							// No acknowledge: a poll restarts with the write control byte; any other command stops
							nack <= (step != 3'h0);
							step <= 3'h0;
							txb <= ctrl(cs, 1'b0);
							phase <= (step == 3'h0 && kind == EE_CMD_POLL) ? 3'h6 : 3'h5;
						end else begin
							bitn <= EE_BIT_RST;
							phase <= 3'h2;
							case (step)
								3'h0: begin
									if (kind == EE_CMD_POLL) begin
										phase <= 3'h5;
									end else if (kind == EE_CMD_CUR) begin
										step <= 3'h5; // Data follows at once
									end else begin
										step <= 3'h1;
										txb <= {1'b0, a[14:8]};
									end
								end
								3'h1: begin
									step <= 3'h2;
									txb <= a[7:0];
								end
								3'h2: begin
									step <= (kind == EE_CMD_READ) ? 3'h4 : 3'h3;
									txb <= (kind == EE_CMD_READ) ? ctrl(cs, 1'b1) : d;
									phase <= (kind == EE_CMD_READ) ? 3'h6 : 3'h2;
								end
								3'h3: begin
									phase <= 3'h5; // Stop begins the write cycle
								end
								3'h4: begin
									step <= 3'h5;
								end
								default: begin
									push <= 1'b1;
									push_data <= rxb;
									left <= left - 8'h1;
									if (left == 8'h1) begin
										phase <= 3'h5;
									end
								end
							endcase
						end
					end
					3'h5: begin
						sda_oe <= 1'b1; // Stop: low, then clock up, then data up
						phase <= 3'h7;
					end
					3'h6: begin
						sda_oe <= 1'b0; // Restart: release data and clock together
						scl_oe <= 1'b0;
						phase <= 3'h0;
					end
					default: begin
						if (scl_oe) begin
							scl_oe <= 1'b0;
						end else begin
							sda_oe <= 1'b0;
							busy_m <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	assign link.scl_m_oe = scl_oe;
	assign link.sda_m_oe = sda_oe;

	// ****************************************************
	// Read data queue; a full queue holds the bus clock
	// ****************************************************
	logic q_in_ready;
	assign fifo_ready = q_in_ready;
	ee_fifo #(.WIDTH(8), .DEPTH(EE_FIFO_DEPTH)) u_q (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_data(push_data),
		.in_valid(push),
		.in_ready(q_in_ready),
		.out_data(rd_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready)
	);
endmodule : ee_master

//--- ee_pkg.sv
// Shared constants and types for the two-wire EEPROM slave and its bus master.
// Assumes one system clock; the serial clock is a sampled signal, not a clock.
package ee_pkg;
	// ****************************************************
	// Addressing
	// ****************************************************
	localparam logic [3:0] EE_DEV_CODE = 4'ha;
	localparam int EE_ADDR_W = 15;
	localparam logic [14:0] EE_ADDR_TOP = 15'h7fff;
	localparam logic [14:0] EE_ADDR_RST = 15'h0000;
	localparam logic [7:0] EE_DATA_RST = 8'h00;
	localparam logic [3:0] EE_BIT_RST = 4'h0;
	localparam logic [3:0] EE_BIT_ACK = 4'h8;
	localparam logic [3:0] EE_BIT_END = 4'h9;
	// ****************************************************
	// Timing
	// ****************************************************
	localparam int EE_CLK_MHZ = 40;
	localparam int EE_WRITE_US = 5000;
	localparam int EE_WRITE_CYC = EE_WRITE_US * EE_CLK_MHZ;
	localparam int EE_SCL_HALF = 100 * EE_CLK_MHZ / 1000;
	localparam logic [7:0] EE_DIV_RST = 8'h00;
	localparam int EE_FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		EE_S_IDLE = 3'b000,
		EE_S_CTRL = 3'b001,
		EE_S_ADRH = 3'b011,
		EE_S_ADRL = 3'b010,
		EE_S_WDAT = 3'b110,
		EE_S_RDAT = 3'b111,
		EE_S_WAIT = 3'b101
	} ee_state_t;

	typedef enum logic [1:0] {
		EE_CMD_WRITE = 2'b00,
		EE_CMD_READ = 2'b01,
		EE_CMD_CUR = 2'b10,
		EE_CMD_POLL = 2'b11
	} ee_cmd_t;

	function automatic logic [14:0] ee_next_addr(input logic [14:0] a);
		ee_next_addr = (a == EE_ADDR_TOP) ? EE_ADDR_RST : a + 15'h0001;
	endfunction : ee_next_addr
endpackage : ee_pkg

//--- ee_slave.sv
// Serial EEPROM slave end: control byte decode, address counter, reads,
// byte writes and acknowledge polling during the self-timed write cycle.
// Assumes the link pins are asynchronous to clk_sys and well slower than it.
`timescale 1ns/100ps
module ee_slave #(
	parameter int WRITE_CYC = ee_pkg::EE_WRITE_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	ee_link_if.slave link,
	input wire logic [2:0] chip_select_bits,
	output logic busy
);
	import ee_pkg::*;

	// ****************************************************
	// Pin synchronisers and bus conditions
	// ****************************************************
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic scl_q;
	logic sda_q;
	logic [2:0] cs_meta;
	logic [2:0] cs_pins;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cs_meta <= 3'h0;
			cs_pins <= 3'h0;
		end else begin
			scl_sync <= {scl_sync[0], link.scl};
			sda_sync <= {sda_sync[0], link.sda};
			scl_q <= scl_sync[1];
			sda_q <= sda_sync[1];
			cs_meta <= chip_select_bits;
			cs_pins <= cs_meta;
		end
	end
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	assign scl_rise = scl_sync[1] && !scl_q;
	assign scl_fall = !scl_sync[1] && scl_q;
	assign start_c = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
	assign stop_c = scl_sync[1] && scl_q && !sda_q && sda_sync[1];

	// ****************************************************
	// Byte shifter and protocol state
	// ****************************************************
	logic [7:0] mem [2**EE_ADDR_W];
	ee_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx;
	logic [14:0] addr;
	logic [14:0] wr_addr;
	logic [7:0] wr_data;
	logic wr_pend;
	logic ack_drive;
	logic rd_drive;
	logic [31:0] wr_timer;
	logic write_go;
	// The falling edge that follows a start carries no bit and must not be counted
	logic scl_hi_seen;

	// One byte completes on the eighth rising edge, before the acknowledge slot
	logic byte_in;
	assign byte_in = scl_rise && (bit_cnt == EE_BIT_RST + 4'h7);
	logic [7:0] rx_byte;
	assign rx_byte = {shift[6:0], sda_q};
	logic ctrl_hit;
	assign ctrl_hit = (rx_byte[7:4] == EE_DEV_CODE)
		&& (rx_byte[3:1] == cs_pins);

	// Control byte decode latched at its eighth bit
	logic ctrl_hit_q;
	logic dir_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl_hit_q <= 1'b0;
			dir_q <= 1'b0;
		end else if (byte_in && state == EE_S_CTRL) begin
			ctrl_hit_q <= ctrl_hit;
			dir_q <= rx_byte[0];
		end
	end

	// Read data goes out MSB first; after the acknowledge slot the next bit is bit 7
	function automatic logic sda_q_ack_n(input logic [3:0] n);
		sda_q_ack_n = tx[3'(4'h7 - ((n == EE_BIT_ACK) ? 4'h0 : n + 4'h1))];
	endfunction : sda_q_ack_n

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state <= EE_S_IDLE;
			bit_cnt <= EE_BIT_RST;
			shift <= EE_DATA_RST;
			ack_drive <= 1'b0;
			rd_drive <= 1'b0;
			addr <= EE_ADDR_RST;
			wr_addr <= EE_ADDR_RST;
			wr_data <= EE_DATA_RST;
			wr_pend <= 1'b0;
			tx <= EE_DATA_RST;
			scl_hi_seen <= 1'b0;
		end else if (start_c || stop_c) begin
			// Any condition ends the byte in flight
			state <= start_c ? EE_S_CTRL : EE_S_IDLE;
			bit_cnt <= EE_BIT_RST;
			ack_drive <= 1'b0;
			rd_drive <= 1'b0;
			scl_hi_seen <= 1'b0;
			// Restart cancels a data write; at a stop write_go has already taken it
			wr_pend <= 1'b0;
		end else if (state != EE_S_IDLE && state != EE_S_WAIT) begin
			if (scl_rise) begin
				scl_hi_seen <= 1'b1;
			end
			if (scl_rise && bit_cnt < EE_BIT_ACK) begin
				shift <= rx_byte;
			end
			if (scl_rise && bit_cnt == EE_BIT_ACK && state == EE_S_RDAT) begin
				if (sda_q) begin
					state <= EE_S_WAIT; // Master declined
				end else begin
					tx <= mem[addr];
					addr <= ee_next_addr(addr);
				end
			end
			if (scl_rise && bit_cnt == EE_BIT_ACK && state == EE_S_CTRL && dir_q) begin
				// Fetch during the acknowledge so bit 7 is ready at its falling edge
				tx <= mem[addr];
				addr <= ee_next_addr(addr);
			end
			if (scl_fall && scl_hi_seen) begin
				bit_cnt <= (bit_cnt == EE_BIT_ACK) ? EE_BIT_RST : bit_cnt + 4'h1;
				if (bit_cnt == EE_BIT_ACK - 4'h1 && state != EE_S_RDAT) begin
					// Acknowledge slot of a received byte
					ack_drive <= (state != EE_S_CTRL) || (ctrl_hit_q && !busy);
					if (state == EE_S_CTRL && !(ctrl_hit_q && !busy)) begin
						state <= EE_S_WAIT;
					end
				end else begin
					ack_drive <= 1'b0;
				end
				if (bit_cnt == EE_BIT_ACK) begin
					case (state)
						EE_S_CTRL: begin
							if (dir_q) begin
								state <= EE_S_RDAT;
							end else begin
								state <= EE_S_ADRH;
							end
						end
						EE_S_ADRH: begin
							addr <= {shift[6:0], addr[7:0]};
							state <= EE_S_ADRL;
						end
						EE_S_ADRL: begin
							addr <= {addr[14:8], shift};
							state <= EE_S_WDAT;
						end
						EE_S_WDAT: begin
							wr_addr <= addr;
							wr_data <= shift;
							wr_pend <= 1'b1;
							addr <= ee_next_addr(addr);
						end
						default: begin
						end
					endcase
				end
				// Next bit goes out while the clock is low; released in the acknowledge slot
				rd_drive <= (state == EE_S_RDAT
					|| (state == EE_S_CTRL && dir_q && bit_cnt == EE_BIT_ACK))
					&& !sda_q_ack_n(bit_cnt) && (bit_cnt != EE_BIT_ACK - 4'h1);
			end
		end
	end

	assign link.sda_s_oe = ack_drive || rd_drive;

	// ****************************************************
	// Self-timed write cycle
	// ****************************************************
	assign write_go = stop_c && wr_pend;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_timer <= 32'h0;
		end else if (write_go) begin
			wr_timer <= 32'(WRITE_CYC);
		end else if (wr_timer != 32'h0) begin
			wr_timer <= wr_timer - 32'h1;
		end
	end
	assign busy = (wr_timer != 32'h0);

	always_ff @(posedge clk_sys) begin
		if (write_go) begin
			mem[wr_addr] <= wr_data;
		end
	end
endmodule : ee_slave

//--- eeprom_read_and_ack_poll_bench.sv
// Bench: slave and master face each other over the link interface.
// Drives the master command port at the falling edge and collects read bytes.
`timescale 1ns/100ps
module eeprom_read_and_ack_poll_bench;
	import ee_pkg::*;
	localparam int WCYC = 200;
	localparam int LIM = 20000;
	localparam logic [2:0] CS = 3'h5;
	localparam logic [14:0] BASE = 15'h7ffa;
	logic clk_sys;
	logic rst;
	logic cmd_valid;
	logic cmd_ready;
	ee_cmd_t cmd;
	logic [2:0] cmd_cs;
	logic [14:0] cmd_addr;
	logic [7:0] cmd_data;
	logic [7:0] cmd_len;
	logic [7:0] rd_data;
	logic rd_valid;
	logic rd_ready;
	logic nack;
	logic busy;
	logic [7:0] got [$];
	int n_errors;
	int check_count;

	ee_link_if link ();
	ee_slave #(.WRITE_CYC(WCYC)) u_ee_slave (.clk_sys(clk_sys), .rst(rst),
		.link(link.slave), .chip_select_bits(CS), .busy(busy));
	ee_master u_ee_master (.clk_sys(clk_sys), .rst(rst), .link(link.master),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .cmd_cs(cmd_cs),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_len(cmd_len), .rd_data(rd_data),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .nack(nack));
	ee_link_assertions #(.WRITE_CYC(WCYC)) u_ee_link_assertions (.clk_sys(clk_sys),
		.rst(rst), .scl_m_oe(link.scl_m_oe), .sda_m_oe(link.sda_m_oe),
		.sda_s_oe(link.sda_s_oe), .scl(link.scl), .sda(link.sda), .busy(busy));

	// ****
	// Tasks
	// ****
	function automatic logic [7:0] pat(input int i);
		pat = {i[3:0], ~i[3:0]};
	endfunction : pat

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	// Ready is a function of master state only, so it is settled at the falling edge
	task automatic wait_ready;
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < LIM) begin
			@(negedge clk_sys);
			n++;
		end
		if (cmd_ready !== 1'b1) begin
			n_errors++;
			give_verdict();
		end
	endtask : wait_ready

	task automatic issue(input ee_cmd_t c, input logic [2:0] cs, input logic [14:0] a,
		input logic [7:0] d, input logic [7:0] len);
		@(negedge clk_sys);
		cmd = c;
		cmd_cs = cs;
		cmd_addr = a;
		cmd_data = d;
		cmd_len = len;
		cmd_valid = 1'b1;
		wait_ready();
		@(negedge clk_sys);
		cmd_valid = 1'b0;
	endtask : issue

	task automatic send(input ee_cmd_t c, input logic [2:0] cs, input logic [14:0] a,
		input logic [7:0] d, input logic [7:0] len);
		issue(c, cs, a, d, len);
		wait_ready();
		repeat (4) @(negedge clk_sys);
	endtask : send

	task automatic write_byte(input logic [14:0] a, input logic [7:0] d);
		send(EE_CMD_WRITE, CS, a, d, 8'h01);
		check("busy after write", {15'h0000, busy}, 16'h0001);
		check("nack after write", {15'h0000, nack}, 16'h0000);
		send(EE_CMD_POLL, CS, a, 8'h00, 8'h01);
		check("busy after poll", {15'h0000, busy}, 16'h0000);
	endtask : write_byte

	task automatic read_one(input ee_cmd_t c, input logic [14:0] a, input logic [7:0] exp);
		got.delete();
		send(c, CS, a, 8'h00, 8'h01);
		check("read count", 16'(got.size()), 16'h0001);
		check("read byte", {8'h00, got[0]}, {8'h00, exp});
	endtask : read_one

	// ****
	// Stimulus
	// ****
	always @(posedge clk_sys) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			got.push_back(rd_data);
		end
	end

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd = EE_CMD_WRITE;
		cmd_cs = CS;
		cmd_addr = 15'h0000;
		cmd_data = 8'h00;
		cmd_len = 8'h01;
		rd_ready = 1'b1;
		n_errors = 0;
		check_count = 0;
		repeat (6) @(negedge clk_sys);
		rst = 1'b0;
		// Twelve bytes straddle the top of the array
		for (int i = 0; i < 12; i++) begin
			write_byte(BASE + 15'(i), pat(i));
		end
		// Consumer stalls so the read buffer fills and holds the bus clock
		rd_ready = 1'b0;
		got.delete();
		issue(EE_CMD_READ, CS, BASE, 8'h00, 8'd12);
		repeat (4000) @(negedge clk_sys);
		check("stall popped", 16'(got.size()), 16'h0000);
		check("stall ready", {15'h0000, cmd_ready}, 16'h0000);
		check("stall valid", {15'h0000, rd_valid}, 16'h0001);
		rd_ready = 1'b1;
		wait_ready();
		repeat (4) @(negedge clk_sys);
		check("seq count", 16'(got.size()), 16'd12);
		for (int i = 0; i < 12; i++) begin
			check("seq byte", {8'h00, got[i]}, {8'h00, pat(i)});
		end
		check("buffer empty", {15'h0000, rd_valid}, 16'h0000);
		read_one(EE_CMD_READ, 15'h7fff, pat(5));
		// Counter left past the top must wrap to the bottom location
		read_one(EE_CMD_CUR, 15'h0000, pat(6));
		// Foreign chip select must be ignored entirely
		send(EE_CMD_WRITE, CS ^ 3'h1, 15'h0000, 8'hff, 8'h01);
		check("busy foreign", {15'h0000, busy}, 16'h0000);
		read_one(EE_CMD_READ, 15'h0000, pat(6));
		read_one(EE_CMD_CUR, 15'h0000, pat(7));
		give_verdict();
	end
endmodule : eeprom_read_and_ack_poll_bench
